// ===== verilog/lmd_pkg.sv
// Constants and carrier types shared by the memory and device bus pin controller
package lmd_pkg;
   localparam int DATA_W = 64;
   localparam int ADDR_W = 32;
   localparam int CHAN_N = 4;
   localparam int DEV_N = 4;
   localparam int BANK_N = 4;
   localparam int LANE_N = 8;
   localparam int BYTE_N = 8;
   localparam int SD_ADDR_W = 11;
   localparam int CYC_W = 4;
   localparam int FIFO_DEPTH = 8;
   localparam int SYNC_STAGES = 3;

   // Positions on the multiplexed bus during a device address phase
   localparam int DIR_BIT = 41;
   localparam int BOOT_BIT = 40;
   localparam int CS_LSB = 36;
   localparam int ACK_LSB = 32;
   localparam int LOW_W = 32;

   // Positions on the SDRAM address lines and the check bit lanes
   localparam int WE_LSB = 3;
   localparam int WE_MSB = 10;
   localparam int BURST_W = 3;
   localparam int ROW_MSB_LANE = 5;
   localparam int BANK1_LANE = 4;
   localparam int ROW_W = 12;

   localparam logic DIR_READ = 1'b1;
   localparam logic DIR_WRITE = 1'b0;
   localparam logic [CYC_W-1:0] CYC_ONE = 4'h1;

   typedef enum logic {LMD_KIND_SDRAM, LMD_KIND_DEVICE} lmd_kind_type;

   typedef struct packed {
      lmd_kind_type kind;
      logic write;
      logic bypass;
      logic dma;
      logic dma_last;
      logic [1:0] dma_chan;
      logic boot;
      logic [1:0] unit;
      logic [ADDR_W-1:0] addr;
      logic [ROW_W-1:0] row;
      logic [SD_ADDR_W-1:0] col;
      logic [1:0] bank_bits;
      logic [DATA_W-1:0] data;
      logic [BYTE_N-1:0] byte_en;
      logic [CYC_W-1:0] cycles;
   } lmd_req_type;

   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic [LANE_N-1:0] check;
   } lmd_rsp_type;
endpackage

// ===== verilog/lmd_sync.sv
// Three-stage synchroniser that accepts a change once the last two stages agree
`timescale 1ns/1ps
module lmd_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [WIDTH-1:0] d_in,
   output logic [WIDTH-1:0] q_out
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         stage1 <= RESET_VAL;
         stage2 <= RESET_VAL;
         stage3 <= RESET_VAL;
      end else begin
         stage1 <= d_in;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // Per bit, a level is taken only when stages two and three agree
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         q_out <= RESET_VAL;
      end else begin
         q_out <= (stage2 & stage3) | (q_out & (stage2 ^ stage3));
      end
   end
endmodule // lmd_sync

// ===== verilog/lmd_fifo.sv
// Request buffer with valid and ready on both sides
`timescale 1ns/1ps
module lmd_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CNT_W = $clog2(DEPTH + 1);
   localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
   localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] next_count;
   logic push;
   logic pop;

   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;
   assign out_data_out = mem[rd_ptr];

   always_comb begin
      next_count = count;
      if (push && !pop) begin
         next_count = count + 1'b1;
      end else if (pop && !push) begin
         next_count = count - 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[wr_ptr] <= in_data_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
         end
      end
   end

   // Flags are registered so that a full buffer really refuses the next word
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         count <= '0;
         in_ready_out <= 1'b0;
         out_valid_out <= 1'b0;
      end else begin
         count <= next_count;
         in_ready_out <= (next_count != FULL_CNT);
         out_valid_out <= (next_count != '0);
      end
   end
endmodule // lmd_fifo

// ===== verilog/lmd_bus_ctrl.sv
// Pin controller for the shared SDRAM and device address/data bus
`timescale 1ns/1ps
module lmd_bus_ctrl #(
   parameter int FIFO_DEPTH = lmd_pkg::FIFO_DEPTH
) (
   input wire logic CLK_IN,
   input wire logic RST_IN,
   input wire logic UMA_STRAP_IN,
   input wire logic TOTAL_REQ_MODE_IN,
   input wire logic REQ_VALID_IN,
   output logic REQ_READY_OUT,
   input wire lmd_pkg::lmd_req_type REQ_IN,
   output logic RSP_VALID_OUT,
   output lmd_pkg::lmd_rsp_type RSP_OUT,
   input wire logic [lmd_pkg::DATA_W-1:0] AD_IN,
   output logic [lmd_pkg::DATA_W-1:0] AD_OUT,
   output logic AD_OE_OUT,
   input wire logic [lmd_pkg::LANE_N-1:0] CHECK_LANES_IN,
   output logic [lmd_pkg::LANE_N-1:0] CHECK_LANES_OUT,
   output logic CHECK_LANES_OE_OUT,
   output logic ADDR_LATCH_N_OUT,
   output logic SELECT_QUALIFY_N_OUT,
   input wire logic READY_N_IN,
   output logic [lmd_pkg::SD_ADDR_W-1:0] SDRAM_ADDRESS_LINES_OUT,
   output logic SDRAM_BANK_BIT0_OUT,
   output logic ROW_STROBE_N_OUT,
   output logic COLUMN_STROBE_N_OUT,
   output logic [lmd_pkg::BANK_N-1:0] SDRAM_BANK_SELECTS_N_OUT,
   output logic [lmd_pkg::BYTE_N-1:0] SDRAM_BYTE_MASKS_N_OUT,
   output logic BYPASS_OUTPUT_ENABLE_N_OUT,
   input wire logic [lmd_pkg::CHAN_N-1:0] DMA_CHANNEL_REQUESTS_N_IN,
   output logic [lmd_pkg::CHAN_N-1:0] DMA_CHANNEL_REQUESTS_OUT,
   input wire logic MEMORY_BUS_REQUEST_N_IN,
   output logic MEMORY_BUS_GRANT_N_OUT,
   output logic INTERNAL_PENDING_REQUEST_N_OUT
);
   localparam int REQ_W = $bits(lmd_pkg::lmd_req_type);

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_GRANT,
      ST_DEV_ADDR,
      ST_DEV_DATA,
      ST_SD_ROW,
      ST_SD_COL,
      ST_SD_DATA
   } lmd_state_type;

   lmd_state_type state;
   lmd_state_type next_state;
   lmd_pkg::lmd_req_type fifo_req;
   lmd_pkg::lmd_req_type cur;
   lmd_pkg::lmd_req_type sel;
   logic fifo_valid;
   logic fifo_pop;
   logic uma_enable;
   logic ready_n_sync;
   logic memory_bus_request_n_sync;
   logic [lmd_pkg::CHAN_N-1:0] dma_req_n_sync;
   logic [lmd_pkg::CYC_W-1:0] cycle_cnt;
   logic dev_done;

   lmd_fifo #(
      .WIDTH(REQ_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_in(CLK_IN),
      .rst_in(RST_IN),
      .in_valid_in(REQ_VALID_IN),
      .in_ready_out(REQ_READY_OUT),
      .in_data_in(REQ_IN),
      .out_valid_out(fifo_valid),
      .out_ready_in(fifo_pop),
      .out_data_out(fifo_req)
   );

   // Ready, request and DMA pins come from outside the clock domain
   lmd_sync #(
      .WIDTH(1),
      .RESET_VAL(1'b1)
   ) u_sync_ready (
      .clk_in(CLK_IN),
      .rst_in(RST_IN),
      .d_in(READY_N_IN),
      .q_out(ready_n_sync)
   );

   lmd_sync #(
      .WIDTH(1),
      .RESET_VAL(1'b1)
   ) u_sync_memory_bus_request (
      .clk_in(CLK_IN),
      .rst_in(RST_IN),
      .d_in(MEMORY_BUS_REQUEST_N_IN),
      .q_out(memory_bus_request_n_sync)
   );

   lmd_sync #(
      .WIDTH(lmd_pkg::CHAN_N),
      .RESET_VAL({lmd_pkg::CHAN_N{1'b1}})
   ) u_sync_dma (
      .clk_in(CLK_IN),
      .rst_in(RST_IN),
      .d_in(DMA_CHANNEL_REQUESTS_N_IN),
      .q_out(dma_req_n_sync)
   );

   // Strap is caught while the synchronous reset is held
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         uma_enable <= UMA_STRAP_IN;
      end
   end

   // Completion needs the programmed count spent and ready seen low
   assign dev_done = (cycle_cnt <= lmd_pkg::CYC_ONE) && !ready_n_sync;
   assign fifo_pop = (state == ST_IDLE) && (next_state != ST_IDLE) && (next_state != ST_GRANT);
   assign sel = (state == ST_IDLE) ? fifo_req : cur;

   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            // A waiting external master goes first so it cannot be starved
            if (uma_enable && !memory_bus_request_n_sync) begin
               next_state = ST_GRANT;
            end else if (fifo_valid) begin
               if (fifo_req.kind == lmd_pkg::LMD_KIND_DEVICE) begin
                  next_state = ST_DEV_ADDR;
               end else begin
                  next_state = ST_SD_ROW;
               end
            end
         end
         ST_GRANT: begin
            if (memory_bus_request_n_sync) begin
               next_state = ST_IDLE;
            end
         end
         ST_DEV_ADDR: begin
            next_state = ST_DEV_DATA;
         end
         ST_DEV_DATA: begin
            if (dev_done) begin
               next_state = ST_IDLE;
            end
         end
         ST_SD_ROW: begin
            next_state = ST_SD_COL;
         end
         ST_SD_COL: begin
            next_state = ST_SD_DATA;
         end
         ST_SD_DATA: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         cur <= '0;
      end else if (fifo_pop) begin
         cur <= fifo_req;
      end
   end

   // Strobe length counter; zero is treated as one cycle
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         cycle_cnt <= '0;
      end else if (state == ST_DEV_ADDR) begin
         cycle_cnt <= cur.cycles;
      end else if (state == ST_DEV_DATA && cycle_cnt > lmd_pkg::CYC_ONE) begin
         cycle_cnt <= cycle_cnt - 1'b1;
      end
   end

   // Pin drive, registered from the state about to be entered
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         AD_OUT <= '0;
         AD_OE_OUT <= 1'b0;
         CHECK_LANES_OUT <= '0;
         CHECK_LANES_OE_OUT <= 1'b0;
         ADDR_LATCH_N_OUT <= 1'b1;
         SELECT_QUALIFY_N_OUT <= 1'b1;
         SDRAM_ADDRESS_LINES_OUT <= '0;
         SDRAM_BANK_BIT0_OUT <= 1'b0;
         ROW_STROBE_N_OUT <= 1'b1;
         COLUMN_STROBE_N_OUT <= 1'b1;
         SDRAM_BANK_SELECTS_N_OUT <= '1;
         SDRAM_BYTE_MASKS_N_OUT <= '1;
         BYPASS_OUTPUT_ENABLE_N_OUT <= 1'b1;
      end else begin
         AD_OUT <= '0;
         AD_OE_OUT <= 1'b0;
         CHECK_LANES_OUT <= '0;
         CHECK_LANES_OE_OUT <= 1'b0;
         ADDR_LATCH_N_OUT <= 1'b1;
         SELECT_QUALIFY_N_OUT <= 1'b1;
         SDRAM_ADDRESS_LINES_OUT <= '0;
         SDRAM_BANK_BIT0_OUT <= 1'b0;
         ROW_STROBE_N_OUT <= 1'b1;
         COLUMN_STROBE_N_OUT <= 1'b1;
         SDRAM_BANK_SELECTS_N_OUT <= '1;
         SDRAM_BYTE_MASKS_N_OUT <= '1;
         BYPASS_OUTPUT_ENABLE_N_OUT <= 1'b1;
         unique case (next_state)
            ST_IDLE, ST_GRANT: begin
            end
            ST_DEV_ADDR: begin
               AD_OE_OUT <= 1'b1;
               AD_OUT[lmd_pkg::LOW_W-1:0] <= sel.addr;
               AD_OUT[lmd_pkg::DIR_BIT] <= sel.write ? lmd_pkg::DIR_WRITE
                                                     : lmd_pkg::DIR_READ;
               AD_OUT[lmd_pkg::BOOT_BIT] <= !sel.boot;
               AD_OUT[lmd_pkg::CS_LSB +: lmd_pkg::DEV_N] <=
                  sel.boot ? '1 : ~(lmd_pkg::DEV_N'(1) << sel.unit);
               AD_OUT[lmd_pkg::ACK_LSB +: lmd_pkg::CHAN_N] <=
                  sel.dma ? ~(lmd_pkg::CHAN_N'(1) << sel.dma_chan) : '1;
               ADDR_LATCH_N_OUT <= 1'b0;
            end
            ST_DEV_DATA: begin
               // Held active through any ready extension as well
               SELECT_QUALIFY_N_OUT <= 1'b0;
               SDRAM_ADDRESS_LINES_OUT[lmd_pkg::BURST_W-1:0] <= sel.addr[lmd_pkg::BURST_W-1:0];
               if (sel.write) begin
                  AD_OE_OUT <= 1'b1;
                  AD_OUT <= sel.data;
                  SDRAM_ADDRESS_LINES_OUT[lmd_pkg::WE_MSB:lmd_pkg::WE_LSB] <= ~sel.byte_en;
               end
               if (sel.dma && sel.dma_last) begin
                  CHECK_LANES_OE_OUT <= 1'b1;
                  CHECK_LANES_OUT <= '1;
                  CHECK_LANES_OUT[lmd_pkg::CHAN_N-1:0] <=
                     ~(lmd_pkg::CHAN_N'(1) << sel.dma_chan);
               end
            end
            ST_SD_ROW: begin
               SDRAM_BANK_SELECTS_N_OUT <= ~(lmd_pkg::BANK_N'(1) << sel.unit);
               ROW_STROBE_N_OUT <= 1'b0;
               SDRAM_ADDRESS_LINES_OUT <= sel.row[lmd_pkg::SD_ADDR_W-1:0];
               SDRAM_BANK_BIT0_OUT <= sel.bank_bits[0];
               CHECK_LANES_OE_OUT <= 1'b1;
               CHECK_LANES_OUT[lmd_pkg::ROW_MSB_LANE] <= sel.row[lmd_pkg::ROW_W-1];
               CHECK_LANES_OUT[lmd_pkg::BANK1_LANE] <= sel.bank_bits[1];
            end
            ST_SD_COL: begin
               SDRAM_BANK_SELECTS_N_OUT <= ~(lmd_pkg::BANK_N'(1) << sel.unit);
               COLUMN_STROBE_N_OUT <= 1'b0;
               SDRAM_ADDRESS_LINES_OUT <= sel.col;
               SDRAM_BANK_BIT0_OUT <= sel.bank_bits[0];
               CHECK_LANES_OE_OUT <= 1'b1;
               CHECK_LANES_OUT[lmd_pkg::BANK1_LANE] <= sel.bank_bits[1];
            end
            ST_SD_DATA: begin
               SDRAM_BANK_SELECTS_N_OUT <= ~(lmd_pkg::BANK_N'(1) << sel.unit);
               if (sel.write) begin
                  AD_OE_OUT <= 1'b1;
                  AD_OUT <= sel.data;
                  CHECK_LANES_OE_OUT <= 1'b1;
                  CHECK_LANES_OUT <= check_bits(sel.data);
                  SDRAM_BYTE_MASKS_N_OUT <= ~sel.byte_en;
               end else begin
                  SDRAM_BYTE_MASKS_N_OUT <= '0;
                  BYPASS_OUTPUT_ENABLE_N_OUT <= !sel.bypass;
               end
            end
         endcase
      end
   end

   // One check bit per byte lane keeps the generator a single gate level
   function automatic logic [lmd_pkg::LANE_N-1:0] check_bits(
      input logic [lmd_pkg::DATA_W-1:0] d
   );
      logic [lmd_pkg::LANE_N-1:0] c;
      c = '0;
      for (int i = 0; i < lmd_pkg::LANE_N; i++) begin
         c[i] = ^d[i*lmd_pkg::BYTE_N +: lmd_pkg::BYTE_N];
      end
      return c;
   endfunction

   // Answer for every finished access; read data from the pins, check bits from the pins on SDRAM reads only
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         RSP_VALID_OUT <= 1'b0;
         RSP_OUT <= '0;
      end else begin
         RSP_VALID_OUT <= 1'b0;
         if (state == ST_DEV_DATA && dev_done) begin
            RSP_VALID_OUT <= 1'b1;
            RSP_OUT.data <= cur.write ? '0 : AD_IN;
            RSP_OUT.check <= '0;
         end else if (state == ST_SD_DATA) begin
            RSP_VALID_OUT <= 1'b1;
            RSP_OUT.data <= cur.write ? '0 : AD_IN;
            RSP_OUT.check <= cur.write ? '0 : CHECK_LANES_IN;
         end
      end
   end

   // Bus ownership signalling for unified memory operation, and DMA request forwarding
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         MEMORY_BUS_GRANT_N_OUT <= 1'b1;
         INTERNAL_PENDING_REQUEST_N_OUT <= 1'b1;
         DMA_CHANNEL_REQUESTS_OUT <= '0;
      end else begin
         MEMORY_BUS_GRANT_N_OUT <= (next_state != ST_GRANT);
         INTERNAL_PENDING_REQUEST_N_OUT <= !(uma_enable && TOTAL_REQ_MODE_IN &&
            (fifo_valid || (state != ST_IDLE && state != ST_GRANT)));
         DMA_CHANNEL_REQUESTS_OUT <= ~dma_req_n_sync;
      end
   end
endmodule // lmd_bus_ctrl

// ===== testbench/lmd_chk.sv
// Bound checker for the shared SDRAM and device bus pins
`timescale 1ns/1ps
module lmd_chk (
   input wire logic CLK_IN,
   input wire logic RST_IN,
   input wire logic TOTAL_REQ_MODE_IN,
   input wire logic REQ_VALID_IN,
   input wire logic REQ_READY_OUT,
   input wire logic RSP_VALID_OUT,
   input wire logic [63:0] AD_OUT,
   input wire logic AD_OE_OUT,
   input wire logic [7:0] CHECK_LANES_OUT,
   input wire logic CHECK_LANES_OE_OUT,
   input wire logic ADDR_LATCH_N_OUT,
   input wire logic SELECT_QUALIFY_N_OUT,
   input wire logic READY_N_IN,
   input wire logic ROW_STROBE_N_OUT,
   input wire logic COLUMN_STROBE_N_OUT,
   input wire logic [3:0] SDRAM_BANK_SELECTS_N_OUT,
   input wire logic BYPASS_OUTPUT_ENABLE_N_OUT,
   input wire logic MEMORY_BUS_REQUEST_N_IN,
   input wire logic MEMORY_BUS_GRANT_N_OUT,
   input wire logic INTERNAL_PENDING_REQUEST_N_OUT
);
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (RST_IN);
   function automatic logic [7:0] par8(input logic [63:0] d);
      for (int i = 0; i < 8; i++) begin
         par8[i] = ^d[8*i+:8];
      end
   endfunction
   sequence addr_then_qualify;
      !ADDR_LATCH_N_OUT ##1 !SELECT_QUALIFY_N_OUT;
   endsequence
   sequence row_then_col;
      !ROW_STROBE_N_OUT ##1 (!COLUMN_STROBE_N_OUT && ROW_STROBE_N_OUT);
   endsequence
   AST_LATCH_DRIVE: assert property (
      !ADDR_LATCH_N_OUT |-> AD_OE_OUT && $countones(~AD_OUT[40:36]) == 1)
      else $error("address phase without exactly one select");
   AST_QUALIFY_AFTER_LATCH: assert property (
      !ADDR_LATCH_N_OUT |-> addr_then_qualify)
      else $error("qualify strobe missing after latch");
   // Five idle ready samples outlast the synchroniser, so the access must stretch
   AST_READY_EXTENDS: assert property (
      READY_N_IN [*5] ##0 !SELECT_QUALIFY_N_OUT |=> !SELECT_QUALIFY_N_OUT && !RSP_VALID_OUT)
      else $error("device access ended without ready");
   AST_ROW_COL_DATA: assert property (
      !ROW_STROBE_N_OUT |-> row_then_col ##2 RSP_VALID_OUT)
      else $error("row, column, answer order broken");
   AST_ONE_BANK: assert property (
      !ROW_STROBE_N_OUT |-> $onehot(~SDRAM_BANK_SELECTS_N_OUT))
      else $error("bank selects not one-hot low");
   AST_CHECK_BITS: assert property (
      $past(!COLUMN_STROBE_N_OUT) && AD_OE_OUT |->
         CHECK_LANES_OE_OUT && CHECK_LANES_OUT == par8(AD_OUT))
      else $error("check lanes wrong on write data");
   AST_BYPASS_READ: assert property (
      !BYPASS_OUTPUT_ENABLE_N_OUT |-> !AD_OE_OUT)
      else $error("bypass open while driving bus");
   AST_GRANT_NEEDS_REQ: assert property (
      MEMORY_BUS_REQUEST_N_IN [*8] |-> MEMORY_BUS_GRANT_N_OUT)
      else $error("grant without request");
   AST_GRANT_IDLE: assert property (
      !MEMORY_BUS_GRANT_N_OUT |-> ADDR_LATCH_N_OUT && ROW_STROBE_N_OUT && !AD_OE_OUT)
      else $error("bus used while granted away");
   AST_PENDING_MODE: assert property (
      !INTERNAL_PENDING_REQUEST_N_OUT |-> $past(TOTAL_REQ_MODE_IN))
      else $error("pending shown with mode off");
   AST_PENDING_SHOWS: assert property (
      REQ_VALID_IN && REQ_READY_OUT && TOTAL_REQ_MODE_IN |->
         ##[1:3] !INTERNAL_PENDING_REQUEST_N_OUT)
      else $error("pending not shown for queued access");
   AST_RESET_IDLE: assert property (disable iff (1'b0)
      RST_IN |=> ADDR_LATCH_N_OUT && SELECT_QUALIFY_N_OUT && !AD_OE_OUT && MEMORY_BUS_GRANT_N_OUT)
      else $error("outputs not idle in reset");
endmodule // lmd_chk
bind lmd_bus_ctrl lmd_chk u_chk (.CLK_IN, .RST_IN, .TOTAL_REQ_MODE_IN, .REQ_VALID_IN,
   .REQ_READY_OUT, .RSP_VALID_OUT, .AD_OUT, .AD_OE_OUT, .CHECK_LANES_OUT,
   .CHECK_LANES_OE_OUT, .ADDR_LATCH_N_OUT, .SELECT_QUALIFY_N_OUT, .READY_N_IN,
   .ROW_STROBE_N_OUT, .COLUMN_STROBE_N_OUT, .SDRAM_BANK_SELECTS_N_OUT,
   .BYPASS_OUTPUT_ENABLE_N_OUT, .MEMORY_BUS_REQUEST_N_IN, .MEMORY_BUS_GRANT_N_OUT,
   .INTERNAL_PENDING_REQUEST_N_OUT);

// ===== testbench/lmd_far_model.sv
// Behavioural SDRAM banks, devices and address latches beyond the bus pins
`timescale 1ns/1ps
module lmd_far_model (
   input wire logic clk_in,
   input wire logic [3:0] wait_in,
   input wire logic [63:0] ad_in,
   input wire logic ad_oe_in,
   input wire logic [7:0] lanes_in,
   input wire logic lanes_oe_in,
   input wire logic latch_n_in,
   input wire logic qual_n_in,
   input wire logic [10:0] sd_addr_in,
   input wire logic bank0_in,
   input wire logic row_n_in,
   input wire logic col_n_in,
   input wire logic [7:0] mask_n_in,
   input wire logic byp_n_in,
   output logic [63:0] ad_out,
   output logic [7:0] lanes_out,
   output logic ready_n_out,
   output logic [41:0] lat_out,
   output logic [24:0] sd_out,
   output logic [7:0] we_out,
   output logic [7:0] mask_out,
   output logic [3:0] eot_out,
   output logic byp_out
);
   logic [3:0] cnt = 4'h0;
   logic [3:0] spin = 4'h0;
   logic rd_slot = 1'b0;
   logic [63:0] rd_data;
   function automatic logic [7:0] par(input logic [63:0] d);
      for (int i = 0; i < 8; i++) begin
         par[i] = ^d[8*i+:8];
      end
   endfunction
   always_ff @(posedge clk_in) begin
      spin <= spin + 4'h1;
      rd_slot <= !col_n_in;
      cnt <= qual_n_in ? 4'h0 : cnt + {3'h0, cnt != 4'hF};
   end
   always_ff @(posedge clk_in) begin
      if (!latch_n_in) lat_out <= ad_in[41:0];
      if (!row_n_in) sd_out[24:11] <= {lanes_in[5], sd_addr_in, lanes_in[4], bank0_in};
      if (!col_n_in) sd_out[10:0] <= sd_addr_in;
      if (rd_slot) mask_out <= mask_n_in;
      if (!qual_n_in && ad_oe_in) we_out <= sd_addr_in[10:3];
      if (!qual_n_in && lanes_oe_in) eot_out <= lanes_in[3:0];
      if (!latch_n_in || !row_n_in) byp_out <= 1'b0;
      if (!byp_n_in) byp_out <= 1'b1;
   end
   // Ready holds to the end of the strobe, so a slow synchroniser still sees it
   assign ready_n_out = qual_n_in || (cnt < wait_in);
   // A released bus shows a moving pattern, never the last driven value
   always_comb begin
      rd_data = {2{5'h15, sd_out[10:0], 5'h0A, sd_out[23:13]}};
      if (ad_oe_in) ad_out = ad_in;
      else if (!qual_n_in && lat_out[41]) ad_out = {~lat_out[31:0], lat_out[31:0]};
      else if (rd_slot) ad_out = rd_data;
      else ad_out = {16{spin}};
      if (lanes_oe_in) lanes_out = lanes_in;
      else if (rd_slot) lanes_out = par(rd_data);
      else lanes_out = {2{spin}};
   end
endmodule // lmd_far_model

// ===== testbench/tb_top.sv
// Self-checking bench for the shared SDRAM and device bus pin controller
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
   $display("unexpected at %0t: got %h, expected %h", $time, a, b); end end
module tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic req_valid = 1'b0;
   lmd_pkg::lmd_req_type req = '0;
   lmd_pkg::lmd_rsp_type rsp;
   logic [63:0] ad_o, ad_i;
   logic [41:0] lat;
   logic [24:0] sd;
   logic [7:0] ln_o, ln_i, mask_n, mask, we;
   logic [10:0] sd_a;
   logic [3:0] sel_n, sel_l, eot, dreq, dreq_n = 4'hF, wait_c = 4'h0;
   logic req_ready, rsp_valid, ad_oe, ln_oe, latch_n, qual_n, ready_n, bank0, row_n, col_n;
   logic byp_n, byp, memory_bus_grant_n, pend_n, memory_bus_request_n = 1'b1, tmode = 1'b1, full_seen = 1'b0;
   int n_fail = 0;
   int check_count = 0;
   lmd_pkg::lmd_req_type exp_q[$];
   always #4 clk = ~clk;
   lmd_bus_ctrl dut (.CLK_IN(clk), .RST_IN(rst), .UMA_STRAP_IN(1'b1), .TOTAL_REQ_MODE_IN(tmode),
      .REQ_VALID_IN(req_valid), .REQ_READY_OUT(req_ready), .REQ_IN(req),
      .RSP_VALID_OUT(rsp_valid), .RSP_OUT(rsp), .AD_IN(ad_i), .AD_OUT(ad_o), .AD_OE_OUT(ad_oe),
      .CHECK_LANES_IN(ln_i), .CHECK_LANES_OUT(ln_o), .CHECK_LANES_OE_OUT(ln_oe),
      .ADDR_LATCH_N_OUT(latch_n), .SELECT_QUALIFY_N_OUT(qual_n), .READY_N_IN(ready_n),
      .SDRAM_ADDRESS_LINES_OUT(sd_a), .SDRAM_BANK_BIT0_OUT(bank0), .ROW_STROBE_N_OUT(row_n),
      .COLUMN_STROBE_N_OUT(col_n), .SDRAM_BANK_SELECTS_N_OUT(sel_n),
      .SDRAM_BYTE_MASKS_N_OUT(mask_n), .BYPASS_OUTPUT_ENABLE_N_OUT(byp_n),
      .DMA_CHANNEL_REQUESTS_N_IN(dreq_n), .DMA_CHANNEL_REQUESTS_OUT(dreq),
      .MEMORY_BUS_REQUEST_N_IN(memory_bus_request_n), .MEMORY_BUS_GRANT_N_OUT(memory_bus_grant_n),
      .INTERNAL_PENDING_REQUEST_N_OUT(pend_n));
   lmd_far_model u_far (.clk_in(clk), .wait_in(wait_c), .ad_in(ad_o), .ad_oe_in(ad_oe),
      .lanes_in(ln_o), .lanes_oe_in(ln_oe), .latch_n_in(latch_n), .qual_n_in(qual_n),
      .sd_addr_in(sd_a), .bank0_in(bank0), .row_n_in(row_n), .col_n_in(col_n),
      .mask_n_in(mask_n), .byp_n_in(byp_n), .ad_out(ad_i), .lanes_out(ln_i),
      .ready_n_out(ready_n), .lat_out(lat), .sd_out(sd), .we_out(we), .mask_out(mask),
      .eot_out(eot), .byp_out(byp));
   function automatic logic [63:0] exp_data(input lmd_pkg::lmd_req_type e);
      if (e.write) return 64'h0;
      if (e.kind == lmd_pkg::LMD_KIND_DEVICE) return {~e.addr, e.addr};
      return {2{5'h15, e.col, 5'h0A, e.row[10:0]}};
   endfunction
   function automatic logic [7:0] exp_chk(input lmd_pkg::lmd_req_type e);
      logic [63:0] d;
      d = exp_data(e);
      for (int i = 0; i < 8; i++) begin
         exp_chk[i] = (e.kind == lmd_pkg::LMD_KIND_SDRAM) && (^d[8*i+:8]);
      end
   endfunction
   function automatic logic [9:0] exp_lat(input lmd_pkg::lmd_req_type e);
      return {!e.write, !e.boot, e.boot ? 4'hF : ~(4'h1 << e.unit),
         e.dma ? ~(4'h1 << e.dma_chan) : 4'hF};
   endfunction
   function automatic lmd_pkg::lmd_req_type rnd_req();
      logic [191:0] b;
      b = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
      return b[$bits(lmd_pkg::lmd_req_type)-1:0];
   endfunction
   always @(posedge clk) begin
      lmd_pkg::lmd_req_type e;
      // Refusal only counts once the buffer really holds its full depth
      if (req_valid && req_ready === 1'b0 && exp_q.size() > lmd_pkg::FIFO_DEPTH) full_seen = 1'b1;
      // Bank selects are idle again by the time the answer is seen
      if (row_n === 1'b0) sel_l = sel_n;
      if (rsp_valid === 1'b1) begin
         e = exp_q.pop_front();
         `CHK(rsp, {exp_data(e), exp_chk(e)})
         if (e.kind == lmd_pkg::LMD_KIND_DEVICE) begin
            `CHK({lat[41:32], lat[31:0]}, {exp_lat(e), e.addr})
            if (e.write) `CHK(we, ~e.byte_en)
            if (e.dma && e.dma_last) `CHK(eot, ~(4'h1 << e.dma_chan))
         end else begin
            `CHK(sd, {e.row, e.bank_bits, e.col})
            `CHK({byp, sel_l}, {!e.write && e.bypass, ~(4'h1 << e.unit)})
            `CHK(mask, e.write ? ~e.byte_en : 8'h00)
         end
      end
   end
   task automatic send(input lmd_pkg::lmd_req_type r);
      req <= r;
      req_valid <= 1'b1;
      exp_q.push_back(r);
      @(posedge clk);
      for (int n = 0; n < 500 && req_ready !== 1'b1; n++) @(posedge clk);
      #1;
   endtask
   task automatic drain();
      for (int n = 0; n < 3000 && exp_q.size() != 0; n++) @(posedge clk);
      repeat (2) @(posedge clk);
      #1;
      `CHK(exp_q.size(), 0)
   endtask
   task automatic close_out();
      $display("comparisons %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Far beyond the thousand or so cycles that the tests need
   initial begin
      #400000;
      n_fail++;
      close_out();
   end
   initial begin
      lmd_pkg::lmd_req_type r;
      void'($urandom(21));
      // Synchronisers reset to idle levels, so three cycles suffice
      repeat (3) @(posedge clk);
      #1;
      rst = 1'b0;
      // Back to back: both kinds and directions, shortest and longest strobe, last DMA
      for (int i = 0; i < 8; i++) begin
         r = rnd_req();
         r.kind = lmd_pkg::lmd_kind_type'(i[0]);
         {r.write, r.boot, r.cycles} = {i[1], i[2], i[2] ? 4'hF : 4'h0};
         {r.unit, r.dma_chan, r.dma, r.dma_last} = {i[1:0], i[2:1], 2'h3};
         send(r);
      end
      req_valid <= 1'b0;
      drain();
      for (int i = 0; i < 40; i++) begin
         wait_c = 4'($urandom_range(6));
         dreq_n = 4'($urandom);
         send(rnd_req());
         req_valid <= 1'b0;
         repeat (6) @(posedge clk);
         `CHK(dreq, ~dreq_n)
         #1;
      end
      drain();
      // Slow device stalls the bus until the buffer refuses
      wait_c = 4'hF;
      for (int i = 0; i < 12; i++) begin
         r = rnd_req();
         {r.kind, r.write, r.cycles} = {lmd_pkg::LMD_KIND_DEVICE, 1'b0, 4'hF};
         send(r);
      end
      req_valid <= 1'b0;
      `CHK(full_seen, 1'b1)
      drain();
      memory_bus_request_n = 1'b0;
      for (int n = 0; n < 10 && memory_bus_grant_n !== 1'b0; n++) @(posedge clk);
      #1;
      `CHK(memory_bus_grant_n, 1'b0)
      send(rnd_req());
      req_valid <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
      `CHK({pend_n, exp_q.size() == 1}, 2'b01)
      tmode = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      `CHK(pend_n, 1'b1)
      memory_bus_request_n = 1'b1;
      drain();
      `CHK(memory_bus_grant_n, 1'b1)
      close_out();
   end
endmodule // tb_top
